// ==== logic/wel_ctrl_pkg.sv ====
// constants for the serial-flash write-enable latch control block
package wel_ctrl_pkg;
    // -----------------------------------------------------------------
    // command opcodes
    // -----------------------------------------------------------------
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
    localparam logic [7:0] OP_BUF_TO_PAGE = 8'h88;
    // -----------------------------------------------------------------
    // transfer shape
    // -----------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] CNT_OPCODE_ONLY = 3'h1;
    localparam logic [2:0] CNT_OPCODE_ADDR = 3'h4;
    localparam logic [2:0] CNT_SATURATE = 3'h7;
    localparam int ADDR_BITS = 24;
    localparam int PAGE_BYTES = 256;
    localparam int BLOCK_SHIFT = 12;
    localparam int ARRAY_ADDR_BITS = 22;
    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic RST_LATCH = 1'h0;
    localparam logic RST_BUSY = 1'h0;
    localparam logic RST_LOCK_BIT = 1'h1;
    localparam logic [2:0] BP_LEVEL_NONE = 3'h0;
    localparam logic [2:0] BP_LEVEL_ALL = 3'h7;
    localparam logic [22:0] BP_UNIT_FINE = 23'h001000;
    localparam logic [22:0] BP_UNIT_COARSE = 23'h010000;
    localparam logic [22:0] ARRAY_BYTES = 23'h400000;

    // commands that need the write-enable latch (01h: the latch or the volatile permission) before they may run
    function automatic logic is_latch_gated(input logic [7:0] op);
        case (op)
            8'h02, 8'hA2, 8'h32, 8'hAF, 8'hAD, 8'h88, 8'h81, 8'hDB,
            8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h9B, 8'h01, 8'h31,
            8'h11, 8'h71, 8'h0A: is_latch_gated = 1'h1;
            default: is_latch_gated = 1'h0;
        endcase
    endfunction
endpackage

// ==== logic/sync2.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync2
    import wel_ctrl_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t s_q, s_d;

    always_comb begin
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
    end

    // reset parks chip select high so no frame is seen at release
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.s2;
endmodule

// ==== logic/spi_byte_shift.sv ====
// serial-to-byte shifter, msb first, with byte-boundary tracking
`timescale 1ns/100ps
module spi_byte_shift
    import wel_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic frame_active,
    input wire logic sck_rise,
    input wire logic si,
    output logic [7:0] byte_val,
    output logic byte_done,
    output logic mid_byte
);
    typedef struct packed {
        logic [7:0] sh;
        logic [2:0] cnt;
        logic done;
    } shift_t;
    shift_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'h0;
        if (!frame_active) begin
            s_d.cnt = 3'h0;
        end else if (sck_rise) begin
            s_d.sh = {s_q.sh[6:0], si};
            s_d.cnt = s_q.cnt + 3'h1;
            s_d.done = (s_q.cnt == 3'(BYTE_BITS - 1));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign byte_val = s_q.sh;
    assign byte_done = s_q.done;
    assign mid_byte = (s_q.cnt != 3'h0);
endmodule

// ==== logic/spi_flash_write_latch_control.sv ====
// write-enable latch, block lock and buffer-to-page program control
`timescale 1ns/100ps
module spi_flash_write_latch_control
    import wel_ctrl_pkg::*;
#(
    parameter int NUM_BLOCKS = 1024
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic block_protect_select,
    input wire logic protect_complement,
    input wire logic protect_granularity,
    input wire logic top_bottom_select,
    input wire logic [2:0] protect_level_bits,
    output logic write_enable_latch,
    output logic ready_busy_flag,
    output logic volatile_write_allow,
    output logic cmd_accept,
    output logic cmd_refuse,
    output logic [7:0] cmd_opcode,
    output logic status_write_volatile,
    output logic prog_write,
    output logic [23:0] prog_addr
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_BUSY = 2'b10
    } state_t;

    typedef struct packed {
        state_t st;
        logic busy;
        logic cs_p;
        logic sck_p;
        logic [2:0] nb;
        logic [7:0] opc;
        logic [23:0] adr;
        logic wel;
        logic vol;
        logic swv;
        logic acc;
        logic refu;
        logic [7:0] op_out;
        logic prog_wr;
        logic [23:0] prog_adr;
        logic [8:0] idx;
        logic [NUM_BLOCKS-1:0] lock;
    } ctrl_t;
    ctrl_t s_q, s_d;

    // -----------------------------------------------------------------
    // pin sampling and byte assembly
    // -----------------------------------------------------------------
    logic [2:0] pins_s;
    logic cs_s, sck_s, si_s;
    logic [7:0] byte_val;
    logic byte_done, mid_byte;

    sync2 #(.W(3)) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din({cs_b, sck, si}),
        .dout(pins_s)
    );
    assign {cs_s, sck_s, si_s} = pins_s;

    logic sck_rise, cs_fall, cs_rise;
    assign sck_rise = sck_s & ~s_q.sck_p;
    assign cs_fall = ~cs_s & s_q.cs_p;
    assign cs_rise = cs_s & ~s_q.cs_p;

    spi_byte_shift u_shift (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .frame_active(~cs_s),
        .sck_rise(sck_rise),
        .si(si_s),
        .byte_val(byte_val),
        .byte_done(byte_done),
        .mid_byte(mid_byte)
    );

    // -----------------------------------------------------------------
    // protection decode
    // -----------------------------------------------------------------
    function automatic logic level_protects(
        input logic [ARRAY_ADDR_BITS-1:0] a,
        input logic cmp,
        input logic gran,
        input logic top,
        input logic [2:0] lvl
    );
        logic [22:0] sz;
        logic hit;
        sz = 23'h0;
        hit = 1'h0;
        if (lvl == BP_LEVEL_ALL) begin
            hit = 1'h1;
        end else if (lvl != BP_LEVEL_NONE) begin
            sz = (gran ? BP_UNIT_FINE : BP_UNIT_COARSE) << (lvl - 3'h1);
            if (sz > ARRAY_BYTES) begin
                sz = ARRAY_BYTES;
            end
            hit = top ? ({1'h0, a} >= (ARRAY_BYTES - sz))
                      : ({1'h0, a} < sz);
        end
        level_protects = hit ^ cmp;
    endfunction

    logic [$clog2(NUM_BLOCKS)-1:0] blk;
    logic page_protected;
    assign blk = s_q.adr[BLOCK_SHIFT +: $clog2(NUM_BLOCKS)];
    always_comb begin
        if (block_protect_select) begin
            page_protected = s_q.lock[blk];
        end else begin
            page_protected = level_protects(
                s_q.adr[ARRAY_ADDR_BITS-1:0], protect_complement,
                protect_granularity, top_bottom_select,
                protect_level_bits);
        end
    end

    // -----------------------------------------------------------------
    // command sequencing
    // -----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.cs_p = cs_s;
        s_d.sck_p = sck_s;
        s_d.acc = 1'h0;
        s_d.refu = 1'h0;
        s_d.prog_wr = 1'h0;
        case (s_q.st)
            ST_IDLE: begin
                // a frame started while busy is never picked up here
                if (cs_fall) begin
                    s_d.st = ST_CMD;
                    s_d.nb = 3'h0;
                end
            end
            ST_CMD: begin
                if (byte_done) begin
                    if (s_q.nb != CNT_SATURATE) begin
                        s_d.nb = s_q.nb + 3'h1;
                    end
                    if (s_q.nb == 3'h0) begin
                        s_d.opc = byte_val;
                        s_d.op_out = byte_val;
                        if (is_latch_gated(byte_val)) begin
                            if (s_q.wel || (byte_val == OP_STATUS_WR
                                            && s_q.vol)) begin
                                s_d.acc = 1'h1;
                                s_d.swv = (byte_val == OP_STATUS_WR)
                                          && s_q.vol;
                            end else begin
                                s_d.refu = 1'h1;
                            end
                        end
                    end else if (s_q.nb < CNT_OPCODE_ADDR) begin
                        s_d.adr = {s_q.adr[15:0], byte_val};
                    end
                end
                if (cs_rise) begin
                    s_d.st = ST_IDLE;
                    // bits left over in a partial byte void the frame
                    if (!mid_byte) begin
                        // only a whole command other than 50h uses it up
                        if (s_q.nb != 3'h0
                            && s_q.opc != OP_VOL_ENABLE) begin
                            s_d.vol = 1'h0;
                        end
                        // extra bytes make these commands malformed, except 88h, which runs with any count of four or more
                        case (s_q.opc)
                            OP_SET_LATCH: begin
                                if (s_q.nb == CNT_OPCODE_ONLY) begin
                                    s_d.wel = 1'h1;
                                end
                            end
                            OP_CLR_LATCH: begin
                                if (s_q.nb == CNT_OPCODE_ONLY) begin
                                    s_d.wel = 1'h0;
                                end
                            end
                            OP_VOL_ENABLE: begin
                                if (s_q.nb == CNT_OPCODE_ONLY) begin
                                    s_d.vol = 1'h1;
                                end
                            end
                            OP_BLOCK_LOCK: begin
                                // lock only taken with latch set
                                if (s_q.nb == CNT_OPCODE_ADDR
                                    && s_q.wel) begin
                                    s_d.lock[blk] = 1'h1;
                                    s_d.wel = 1'h0;
                                end
                            end
                            OP_BUF_TO_PAGE: begin
                                if (s_q.wel && s_q.nb != 3'h0) begin
                                    s_d.wel = 1'h0;
                                    if (s_q.nb >= CNT_OPCODE_ADDR
                                        && !page_protected) begin
                                        s_d.st = ST_BUSY;
                                        s_d.idx = 9'h0;
                                    end
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            ST_BUSY: begin
                if (s_q.idx == 9'(PAGE_BYTES)) begin
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.prog_wr = 1'h1;
                    s_d.prog_adr = {s_q.adr[23:8], s_q.idx[7:0]};
                    s_d.idx = s_q.idx + 9'h1;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        s_d.busy = (s_d.st == ST_BUSY);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.cs_p <= 1'h1;
            // matches the synchroniser's reset level: no false sck edge
            s_q.sck_p <= 1'h1;
            s_q.wel <= RST_LATCH;
            s_q.lock <= {NUM_BLOCKS{RST_LOCK_BIT}};
        end else begin
            s_q <= s_d;
        end
    end

    assign write_enable_latch = s_q.wel;
    assign ready_busy_flag = s_q.busy;
    assign volatile_write_allow = s_q.vol;
    assign cmd_accept = s_q.acc;
    assign cmd_refuse = s_q.refu;
    assign cmd_opcode = s_q.op_out;
    assign status_write_volatile = s_q.swv;
    assign prog_write = s_q.prog_wr;
    assign prog_addr = s_q.prog_adr;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    logic [9:0] wr_cnt;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || s_q.st != ST_BUSY) begin
            wr_cnt <= 10'h0;
        end else if (prog_write) begin
            wr_cnt <= wr_cnt + 10'h1;
        end
    end

    logic end_ok;
    assign end_ok = (s_q.st == ST_CMD) && cs_rise && !mid_byte;

    sequence prog_start_s;
        end_ok && s_q.opc == OP_BUF_TO_PAGE && s_q.wel
        && s_q.nb >= CNT_OPCODE_ADDR && !page_protected;
    endsequence
    sequence prog_run_s;
        ready_busy_flag[*8] ##1 prog_write;
    endsequence

    chk_busy_during_prog: assert property (@(posedge clk_sys)
        disable iff (!rst_b) prog_start_s |=> prog_run_s)
        else $error("busy flag not held during page program");
    chk_busy_clears: assert property (@(posedge clk_sys)
        disable iff (!rst_b) prog_start_s |-> ##[258:260] !ready_busy_flag)
        else $error("busy flag did not clear after program");
    chk_latch_low_busy: assert property (@(posedge clk_sys)
        disable iff (!rst_b) ready_busy_flag |-> !write_enable_latch)
        else $error("latch still set during program cycle");
    chk_protect_skip: assert property (@(posedge clk_sys)
        disable iff (!rst_b) end_ok && s_q.opc == OP_BUF_TO_PAGE
        && s_q.wel && s_q.nb >= CNT_OPCODE_ADDR && page_protected
        |=> !ready_busy_flag && !write_enable_latch)
        else $error("protected page was programmed");
    chk_short_addr: assert property (@(posedge clk_sys)
        disable iff (!rst_b) end_ok && s_q.opc == OP_BUF_TO_PAGE
        && s_q.wel && s_q.nb != 3'h0 && s_q.nb < CNT_OPCODE_ADDR
        |=> !ready_busy_flag && !write_enable_latch)
        else $error("short address did not abort program");
    chk_mid_byte_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_b) s_q.st == ST_CMD && cs_rise && mid_byte
        |=> $stable(write_enable_latch) && $stable(s_q.lock)
        && $stable(volatile_write_allow) && !ready_busy_flag)
        else $error("state changed on mid-byte release");
    chk_set_latch: assert property (@(posedge clk_sys)
        disable iff (!rst_b) end_ok && s_q.opc == OP_SET_LATCH
        && s_q.nb == CNT_OPCODE_ONLY |=> write_enable_latch)
        else $error("set command did not set latch");
    chk_clear_latch: assert property (@(posedge clk_sys)
        disable iff (!rst_b) end_ok && s_q.opc == OP_CLR_LATCH
        && s_q.nb == CNT_OPCODE_ONLY |=> !write_enable_latch)
        else $error("clear command did not clear latch");
    chk_refuse_gated: assert property (@(posedge clk_sys)
        disable iff (!rst_b) cmd_accept |-> $past(s_q.wel)
        || (cmd_opcode == OP_STATUS_WR && $past(s_q.vol)))
        else $error("gated command accepted without latch");
    chk_vol_no_latch: assert property (@(posedge clk_sys)
        disable iff (!rst_b) end_ok && s_q.opc == OP_VOL_ENABLE
        && s_q.nb == CNT_OPCODE_ONLY
        |=> volatile_write_allow && $stable(write_enable_latch))
        else $error("volatile enable misbehaved");
    chk_lock_set: assert property (@(posedge clk_sys)
        disable iff (!rst_b) end_ok && s_q.opc == OP_BLOCK_LOCK
        && s_q.nb == CNT_OPCODE_ADDR && s_q.wel
        |=> s_q.lock[$past(blk)] && !write_enable_latch)
        else $error("block lock not applied");
    chk_full_page: assert property (@(posedge clk_sys)
        disable iff (!rst_b) $fell(ready_busy_flag) |-> wr_cnt
        == 10'(PAGE_BYTES))
        else $error("page program did not write every byte");
endmodule

// ==== tb/spi_host_model.sv ====
// serial host model: drives chip select, serial clock and data
`timescale 1ns/100ps
module spi_host_model (
    input wire logic clk_sys,
    output logic cs_b,
    output logic sck,
    output logic si
);
    initial begin
        cs_b = 1'h1;
        sck = 1'h0;
        si = 1'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // -----------------------------------------------------------------
    // one frame: data left-aligned, nbits may stop mid-byte on purpose
    // -----------------------------------------------------------------
    task automatic send(input logic [31:0] data, input int nbits);
        int i;
        @(posedge clk_sys);
        cs_b <= 1'h0;
        wait_clk(4);
        for (i = 0; i < nbits; i++) begin
            si <= data[31 - i];
            wait_clk(4);
            sck <= 1'h1;
            wait_clk(4);
            sck <= 1'h0;
        end
        wait_clk(4);
        cs_b <= 1'h1;
        // released line must not keep the last bit
        si <= ~si;
        wait_clk(8);
    endtask
endmodule

// ==== tb/spi_flash_write_latch_control_tb.sv ====
// self-checking bench for the write-enable latch control block
`timescale 1ns/100ps
module spi_flash_write_latch_control_tb;
    import wel_ctrl_pkg::*;
    logic clk_sys, rst_b, cs_b, sck, si, bps, cmp, gran, top;
    logic [2:0] lvl;
    logic write_enable_latch, ready_busy_flag, volatile_write_allow;
    logic cmd_accept, cmd_refuse, status_write_volatile, prog_write;
    logic [7:0] cmd_opcode;
    logic [23:0] prog_addr, last_addr;
    int n_errors = 0;
    int compares = 0;
    int n_acc = 0;
    int n_ref = 0;
    int n_prog = 0;
    int n_badbusy = 0;
    int cyc = 0;
    int m;
    logic [7:0] gated [19] = '{8'h02, 8'hA2, 8'h32, 8'hAF, 8'hAD, 8'h88,
        8'h81, 8'hDB, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h9B, 8'h01,
        8'h31, 8'h11, 8'h71, 8'h0A};

    spi_flash_write_latch_control u_spi_flash_write_latch_control (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .cs_b(cs_b),
        .sck(sck),
        .si(si),
        .block_protect_select(bps),
        .protect_complement(cmp),
        .protect_granularity(gran),
        .top_bottom_select(top),
        .protect_level_bits(lvl),
        .write_enable_latch(write_enable_latch),
        .ready_busy_flag(ready_busy_flag),
        .volatile_write_allow(volatile_write_allow),
        .cmd_accept(cmd_accept),
        .cmd_refuse(cmd_refuse),
        .cmd_opcode(cmd_opcode),
        .status_write_volatile(status_write_volatile),
        .prog_write(prog_write),
        .prog_addr(prog_addr)
    );

    spi_host_model u_spi_host_model (
        .clk_sys(clk_sys),
        .cs_b(cs_b),
        .sck(sck),
        .si(si)
    );

    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    // -----------------------------------------------------------------
    // pulse monitors: one-cycle outputs are counted where they stand
    // -----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (cmd_accept === 1'h1)
            n_acc++;
        if (cmd_refuse === 1'h1)
            n_ref++;
        if (prog_write === 1'h1) begin
            n_prog++;
            last_addr = prog_addr;
            if (ready_busy_flag !== 1'h1)
                n_badbusy++;
        end
        if (cyc == 30000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic cmd(input logic [31:0] d, input int n);
        u_spi_host_model.send(d, n);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (ready_busy_flag !== 1'h0 && k < 400) begin
            @(posedge clk_sys);
            k++;
        end
        check("idle", ready_busy_flag, 0);
    endtask

    task automatic end_sim();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        rst_b = 1'h0;
        bps = 1'h1;
        cmp = 1'h0;
        gran = 1'h0;
        top = 1'h0;
        lvl = 3'h0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk_sys);
        m = n_ref;
        foreach (gated[i])
            cmd({gated[i], 24'h0}, 8);
        check("refused", n_ref - m, 19);
        check("accepted", n_acc, 0);
        cmd({OP_SET_LATCH, 24'h0}, 12);
        check("latch_mid", write_enable_latch, 0);
        cmd({OP_SET_LATCH, 24'h0}, 8);
        check("latch_set", write_enable_latch, 1);
        check("opcode", cmd_opcode, OP_SET_LATCH);
        cmd({OP_CLR_LATCH, 24'h0}, 16);
        check("clr_long", write_enable_latch, 1);
        cmd({OP_CLR_LATCH, 24'h0}, 8);
        check("latch_clr", write_enable_latch, 0);
        // every block starts locked, so this page program is skipped
        m = n_prog;
        cmd({OP_SET_LATCH, 24'h0}, 8);
        cmd({OP_BUF_TO_PAGE, 24'h123456}, 32);
        wait_idle();
        check("prog_locked", n_prog - m, 0);
        check("latch_locked", write_enable_latch, 0);
        cmd({OP_SET_LATCH, 24'h0}, 8);
        cmd({OP_BLOCK_LOCK, 24'h001000}, 16);
        check("lock_short", write_enable_latch, 1);
        cmd({OP_BLOCK_LOCK, 24'h001000}, 32);
        check("lock_latch", write_enable_latch, 0);
        cmd({OP_SET_LATCH, 24'h0}, 8);
        cmd({OP_BUF_TO_PAGE, 24'h123456}, 24);
        wait_idle();
        check("short_latch", write_enable_latch, 0);
        check("short_prog", n_prog - m, 0);
        @(posedge clk_sys);
        bps <= 1'h0;
        lvl <= 3'h7;
        cmd({OP_SET_LATCH, 24'h0}, 8);
        cmd({OP_BUF_TO_PAGE, 24'h123456}, 32);
        wait_idle();
        check("lvl_prog", n_prog - m, 0);
        check("lvl_latch", write_enable_latch, 0);
        lvl <= 3'h0;
        cmd({OP_SET_LATCH, 24'h0}, 8);
        cmd({OP_BUF_TO_PAGE, 24'h123456}, 32);
        check("busy", ready_busy_flag, 1);
        wait_idle();
        check("prog_count", n_prog - m, PAGE_BYTES);
        check("prog_last", last_addr, 24'h1234FF);
        check("busy_prog", n_badbusy, 0);
        check("prog_latch", write_enable_latch, 0);
        cmd({OP_VOL_ENABLE, 24'h0}, 8);
        check("vol_set", volatile_write_allow, 1);
        check("vol_latch", write_enable_latch, 0);
        cmd({OP_SET_LATCH, 24'h0}, 12);
        check("vol_mid", volatile_write_allow, 1);
        cmd({OP_SET_LATCH, 24'h0}, 8);
        check("vol_drop", volatile_write_allow, 0);
        // latch cleared so only the one-shot permission admits 01h
        cmd({OP_CLR_LATCH, 24'h0}, 8);
        cmd({OP_VOL_ENABLE, 24'h0}, 8);
        m = n_acc;
        cmd({OP_STATUS_WR, 8'h5A, 16'h0}, 16);
        check("st_acc", n_acc - m, 1);
        check("st_vol", status_write_volatile, 1);
        check("vol_used", volatile_write_allow, 0);
        check("st_op", cmd_opcode, OP_STATUS_WR);
        m = n_ref;
        cmd({OP_STATUS_WR, 8'h5A, 16'h0}, 16);
        check("st_once", n_ref - m, 1);
        end_sim();
    end
endmodule
